/* File: hdl/ccps_sync.sv */
module ccps_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // change accepted only when second and third stage agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule

/* File: hdl/ccps_top.sv */
// Function
// [R1] no mode input selects single cycle
// [R2] one mode input sets intervention count
// [R3] several modes is error, enable off
// [R4] output flags multiple modes selected
// [R5] output flags start button needed
// [R6] count interventions after power-up before movement
// [R7] start with clear field enables cycle
// [R8] reset input opening drops enable, recounts; count is cleared only if it opens in CCPS_RUN
// [R9] intervention during movement stops, full recount
// [R10] muting bridges both curtain channels
// [R11] input skips minimum interruption supervision
// [R12] field flag 0 free, 1 interrupted
// [R13] restart flag 0 inhibited, 1 not
// [R14] flags show running working and interrupt timers
// [R15] stores for start after timer, with button
// [R16] light curtain monitors its own channels
// [R17] muting driven by suitable sensor evaluation
// [R18] init flag set until first evaluation
// [R19] working time expiry drops enable
module ccps_top #(
  parameter int unsigned WORK_CYC = ccps_pkg::WORK_TIME_CYC,
  parameter int unsigned MINT_CYC = ccps_pkg::MIN_INT_CYC,
  parameter int unsigned SYNC_CYC = ccps_pkg::SYNC_WIN_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start,
  input  wire logic i_mode_1,
  input  wire logic i_mode_2,
  input  wire logic i_mode_3,
  input  wire logic i_mode_4,
  input  wire logic i_curtain_channel_1,
  input  wire logic i_curtain_channel_2,
  input  wire logic i_cycle_reset_in,
  input  wire logic i_muting_in,
  input  wire logic i_no_min_interrupt_in,
  input  wire logic i_restart_free,
  output logic      o_cycle_enable_out,
  output logic      o_multi_mode_signal,
  output logic      o_start_needed_signal,
  output logic      o_start_after_timer_store,
  output logic      o_start_after_timer_button_store,
  output logic      o_field_state,
  output logic      o_restart_inhibit,
  output logic      o_working_time_timer,
  output logic      o_min_interrupt_timer,
  output logic      o_init_flag
);
  import ccps_pkg::*;

  logic [9:0] raw;
  logic [9:0] syn;
  assign raw = {i_restart_free, i_no_min_interrupt_in, i_muting_in, i_cycle_reset_in,
                i_curtain_channel_2, i_curtain_channel_1, i_mode_4, i_mode_3,
                i_mode_2, i_mode_1};

  // pins come from outside the clock domain, so every one is synchronised
  for (genvar g = 0; g < 10; g++) begin : g_sync
    ccps_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async (raw[g]),
      .o_level (syn[g])
    );
  end

  logic start_s;
  ccps_sync u_start (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_start),
    .o_level (start_s)
  );

  wire [3:0] modes   = syn[3:0];
  wire       ch1     = syn[4];
  wire       ch2     = syn[5];
  wire       cyc_rst = syn[6];
  wire       muting  = syn[7];
  wire       no_mint = syn[8];
  wire       rst_free = syn[9];

  wire [2:0] mode_cnt = 3'(modes[0]) + 3'(modes[1]) + 3'(modes[2]) + 3'(modes[3]);
  wire       multi    = (mode_cnt > 3'h1);                              // [R3]
  wire [2:0] need     = modes[3] ? 3'h4 : modes[2] ? 3'h3 :
                        modes[1] ? 3'h2 : CYCLES_DEFAULT;               // [R1] [R2]

  // muting bridges both channels as clear
  wire ch1_b  = ch1 | muting;                                         // [R10]
  wire ch2_b  = ch2 | muting;                                         // [R10]
  wire both_clear = ch1_b & ch2_b;
  wire both_open  = ~ch1_b & ~ch2_b;
  wire mismatch   = ch1_b ^ ch2_b;

  logic        field_q;
  logic [2:0]  cnt_q;
  logic [31:0] mint_q;
  logic [31:0] sync_q;
  logic [31:0] work_q;
  logic        work_run_q;
  logic        mint_run_q;
  logic        valid_int_q;
  logic        start_d1_q;
  logic        cyc_rst_d1_q;
  logic        fault_q;
  logic        init_q;
  logic        restart_q;
  ccps_state_t state_q;
  ccps_state_t state_d;

  wire start_rise  = start_s & ~start_d1_q;
  wire reset_open  = ~cyc_rst & cyc_rst_d1_q;                          // [R8]
  wire mint_done   = mint_run_q && (mint_q >= MINT_CYC - 1);
  // an interruption counts once the field clears again after a valid break
  wire intervention = field_q & both_clear & ~fault_q &
                      (no_mint | valid_int_q | mint_done);           // [R11]
  wire work_expire = work_run_q && (work_q >= WORK_CYC - 1);
  wire count_full  = (cnt_q >= need);
  wire run_stop    = ~both_clear | reset_open | work_expire | multi;

  always_comb begin
    state_d = state_q;
    case (state_q)
      CCPS_COUNT:   if (count_full && !multi) state_d = CCPS_WAIT_ST;   // [R6]
      CCPS_WAIT_ST: begin
        if (multi) state_d = CCPS_COUNT;
        else if (start_rise && both_clear && cyc_rst) state_d = CCPS_RUN; // [R7]
      end
      CCPS_RUN:     if (run_stop) state_d = CCPS_COUNT;                 // [R8] [R9] [R19]
      CCPS_HOLD:    state_d = CCPS_COUNT;
      default:      state_d = CCPS_COUNT;
    endcase
  end

  wire leaving_run = (state_q == CCPS_RUN) && (state_d != CCPS_RUN);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q      <= CCPS_COUNT;
      start_d1_q   <= 1'b0;
      cyc_rst_d1_q <= 1'b0;
      init_q       <= 1'b1;
      restart_q    <= RESTART_INH_RST;
    end else begin
      state_q      <= state_d;
      start_d1_q   <= start_s;
      cyc_rst_d1_q <= cyc_rst;
      init_q       <= 1'b0;                                            // [R18]
      restart_q    <= rst_free;                                        // [R13]
    end
  end

  // field memory and intervention counter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      field_q <= 1'b0;
      cnt_q   <= 3'h0;
    end else begin
      if (!both_clear) field_q <= 1'b1;                                // [R12]
      else if (field_q) field_q <= 1'b0;
      if (leaving_run || multi) cnt_q <= 3'h0;                          // [R9]
      else if (state_q == CCPS_COUNT && intervention && !count_full)
        cnt_q <= cnt_q + 3'h1;                                          // [R6]
    end
  end

  // minimum interruption timer and channel synchronism check
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mint_q      <= 32'h0;
      mint_run_q  <= 1'b0;
      valid_int_q <= 1'b0;
      sync_q      <= 32'h0;
      fault_q     <= 1'b0;
    end else begin
      if (both_clear) begin
        mint_q      <= 32'h0;
        mint_run_q  <= 1'b0;
        valid_int_q <= 1'b0;
      end else if (both_open && !no_mint) begin                         // [R11]
        mint_run_q <= ~mint_done & ~valid_int_q;                        // [R14]
        if (mint_done) valid_int_q <= 1'b1;
        mint_q <= mint_q + 32'h1;
      end
      // channels must agree again within the sync window, whichever way they switch
      if (mismatch) sync_q <= sync_q + 32'h1;
      else sync_q <= 32'h0;
      if (mismatch && sync_q >= SYNC_CYC - 1) fault_q <= 1'b1;
      else if (both_clear && !field_q) fault_q <= 1'b0;
    end
  end

  // working time timer runs while the movement is enabled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      work_q     <= 32'h0;
      work_run_q <= 1'b0;
    end else if (state_d == CCPS_RUN) begin
      work_run_q <= 1'b1;                                               // [R14]
      work_q     <= (state_q == CCPS_RUN) ? work_q + 32'h1 : 32'h0;
    end else begin
      work_run_q <= 1'b0;
      work_q     <= 32'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cycle_enable_out               <= 1'b0;
      o_multi_mode_signal              <= 1'b0;
      o_start_needed_signal            <= 1'b0;
      o_start_after_timer_store        <= 1'b0;
      o_start_after_timer_button_store <= 1'b0;
      o_field_state                    <= 1'b0;
      o_restart_inhibit                <= 1'b0;
      o_working_time_timer             <= 1'b0;
      o_min_interrupt_timer            <= 1'b0;
      o_init_flag                      <= 1'b1;
    end else begin
      o_cycle_enable_out    <= (state_d == CCPS_RUN) && !multi;         // [R3] [R7]
      o_multi_mode_signal   <= multi;                                   // [R4]
      o_start_needed_signal <= (state_d == CCPS_WAIT_ST);               // [R5]
      o_start_after_timer_store        <= (state_d == CCPS_WAIT_ST) ||
                                          (state_d == CCPS_RUN);        // [R15]
      o_start_after_timer_button_store <= (state_d == CCPS_RUN);        // [R15]
      o_field_state         <= field_q;                                 // [R12]
      o_restart_inhibit     <= restart_q;                               // [R13]
      o_working_time_timer  <= work_run_q;                              // [R14]
      o_min_interrupt_timer <= mint_run_q;                              // [R14]
      o_init_flag           <= init_q;                                  // [R18]
    end
  end

  enable_multi_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    multi |=> ##1 !o_cycle_enable_out) else $error("enable with multiple modes"); // [R3]
  multi_sig_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    multi |=> o_multi_mode_signal) else $error("multi mode not signalled"); // [R4]
  start_sig_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_start_needed_signal |-> !o_cycle_enable_out) else $error("start and enable"); // [R5]
  count_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CCPS_RUN) |-> cnt_q >= need || multi) else $error("run without count"); // [R6]
  enable_rise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_cycle_enable_out) |-> $past(start_rise, 1)) else $error("enable w/o start"); // [R7]
  reset_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CCPS_RUN && reset_open) |=> !o_cycle_enable_out) else $error("no drop"); // [R8]
  field_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CCPS_RUN && !both_clear) |=> cnt_q == 3'h0) else $error("no recount"); // [R9]
  default_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (modes == 4'h0) |-> need == 3'h1) else $error("default not single"); // [R1]
  work_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CCPS_RUN && work_expire) |=> !o_cycle_enable_out) else $error("timeout"); // [R19]
  init_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !init_q |=> !o_init_flag) else $error("init flag stuck"); // [R18]
  mode_two_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (modes == 4'h2) |-> need == 3'h2) else $error("two cycle count wrong"); // [R2]
  // muted channels must look clear whatever the curtain reports
  mute_bridge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    muting |-> both_clear) else $error("muting not bridged"); // [R10]
  // field flag passes field memory and output stage, two edges
  field_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !both_clear |=> ##1 o_field_state) else $error("field flag not set"); // [R12]
  restart_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    restart_q |=> o_restart_inhibit) else $error("restart flag wrong"); // [R13]
  work_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CCPS_RUN) |=> o_working_time_timer) else $error("work flag off"); // [R14]
  mint_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mint_run_q |=> o_min_interrupt_timer) else $error("interrupt flag off"); // [R14]
  store_run_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == CCPS_RUN) |-> o_start_after_timer_button_store) else $error("store off"); // [R15]

  run_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_cycle_enable_out));
  multi_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_multi_mode_signal));
  stop_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == CCPS_RUN && !both_clear);
  // count reached and the working time running out are the other main paths
  armed_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_start_needed_signal));
  expire_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == CCPS_RUN && work_expire);
endmodule

/* File: include/ccps_pkg.sv */
package ccps_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  // working time default (seconds); adjustable range 30..120
  localparam int unsigned WORK_TIME_S      = 30;
  localparam int unsigned WORK_TIME_CYC    = WORK_TIME_S * CLK_HZ;
  // fixed minimum interruption time of the curtain channels, ms
  localparam int unsigned MIN_INT_MS       = 100;
  localparam int unsigned MIN_INT_CYC      = MIN_INT_MS * (CLK_HZ / 1000);
  // synchronisation window between the two channels, us
  localparam int unsigned SYNC_WIN_US      = 500;
  localparam int unsigned SYNC_WIN_CYC     = SYNC_WIN_US * (CLK_HZ / 1_000_000);
  localparam logic [2:0]  CYCLES_DEFAULT   = 3'h1;
  localparam logic        RESTART_INH_RST  = 1'b0;

  typedef enum logic [1:0] {
    CCPS_COUNT   = 2'b00,
    CCPS_WAIT_ST = 2'b01,
    CCPS_RUN     = 2'b10,
    CCPS_HOLD    = 2'b11
  } ccps_state_t;
endpackage

/* File: verification/ccps_curtain_model.sv */
// light curtain plus muting evaluation on the far side of the block
module ccps_curtain_model (
  input  wire logic i_clk,
  input  wire logic i_break,
  input  wire logic i_mute_req,
  output logic      o_ch1,
  output logic      o_ch2,
  output logic      o_muting
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_ch1 = 1'b1;
    o_ch2 = 1'b1;
    o_muting = 1'b0;
  end
  // both channels switch together: the curtain checks its own outputs
  always @(posedge i_clk) begin
    #1;
    o_ch1 = ~i_break;
    o_ch2 = ~i_break;
    // muting comes from an already evaluated sensor pair, one clean level
    o_muting = i_mute_req;
  end
endmodule

/* File: verification/ccps_top_tb.sv */
module ccps_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WK = 400;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start = 1'b0;
  logic       rst_in = 1'b1;
  logic       nomin = 1'b0;
  logic       rfree = 1'b0;
  logic       brk = 1'b0;
  logic       mreq = 1'b0;
  logic [3:0] mode = 4'h0;
  wire        ch1, ch2, mute;
  logic       en, multi, need, start_after_timer_store, gz, field, rinh, t1, t2, init;
  int         err_count = 0;
  int         n_compared = 0;
  always #5 clk = ~clk;
  ccps_curtain_model i_ccps_curtain_model (.i_clk(clk), .i_break(brk), .i_mute_req(mreq),
    .o_ch1(ch1), .o_ch2(ch2), .o_muting(mute));
  ccps_top #(.WORK_CYC(WK), .MINT_CYC(10), .SYNC_CYC(5)) i_ccps_top (
    .i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_mode_1(mode[0]), .i_mode_2(mode[1]),
    .i_mode_3(mode[2]), .i_mode_4(mode[3]), .i_curtain_channel_1(ch1),
    .i_curtain_channel_2(ch2), .i_cycle_reset_in(rst_in), .i_muting_in(mute),
    .i_no_min_interrupt_in(nomin), .i_restart_free(rfree), .o_cycle_enable_out(en),
    .o_multi_mode_signal(multi), .o_start_needed_signal(need),
    .o_start_after_timer_store(start_after_timer_store), .o_start_after_timer_button_store(gz),
    .o_field_state(field), .o_restart_inhibit(rinh), .o_working_time_timer(t1),
    .o_min_interrupt_timer(t2), .o_init_flag(init));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR %s expected %b seen %b", name, exp, seen);
      err_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? en : (s == 1) ? need : t2;
  endfunction
  // bounded poll; running out of cycles is a mismatch and ends the run
  task automatic waitv(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (pick(s) === v) break;
      cyc(1);
    end
    if (i == lim) begin
      $display("ERROR wait %0d expected %b seen %b", s, v, pick(s));
      err_count++;
      close_out();
    end
  endtask
  task automatic hit(input int len);
    brk = 1'b1;
    cyc(len);
    brk = 1'b0;
    cyc(20);
  endtask
  task automatic recount();
    rst_in = 1'b0;
    cyc(12);
    rst_in = 1'b1;
    cyc(12);
  endtask
  task automatic arm(input int n);
    recount();
    repeat (n) hit(20);
    waitv(1, 1'b1, 40);
    start = 1'b1;
    waitv(0, 1'b1, 40);
    start = 1'b0;
  endtask
  task automatic t_modes();
    for (int k = 0; k < 5; k++) begin
      mode = (k == 0) ? 4'h0 : 4'(1 << (k - 1));
      recount();
      repeat ((k == 0 ? 1 : k) - 1) hit(20);
      check("need_early", need, 1'b0);
      start = 1'b1;
      cyc(12);
      check("en_early", en, 1'b0);
      start = 1'b0;
      hit(20);
      check("need", need, 1'b1);
      check("store_timer", start_after_timer_store, 1'b1);
      check("store_button_idle", gz, 1'b0);
      start = 1'b1;
      waitv(0, 1'b1, 40);
      cyc(1);
      check("t1_run", t1, 1'b1);
      check("store_button", gz, 1'b1);
      start = 1'b0;
      rst_in = 1'b0;
      waitv(0, 1'b0, 40);
      rst_in = 1'b1;
    end
  endtask
  task automatic t_multi();
    mode = 4'h3;
    cyc(12);
    check("multi", multi, 1'b1);
    hit(20);
    start = 1'b1;
    cyc(12);
    check("en_multi", en, 1'b0);
    start = 1'b0;
    mode = 4'h2;
    cyc(12);
    check("multi_off", multi, 1'b0);
  endtask
  task automatic t_break();
    arm(2);
    brk = 1'b1;
    waitv(0, 1'b0, 40);
    cyc(1);
    check("field_hit", field, 1'b1);
    brk = 1'b0;
    cyc(20);
    check("field_free", field, 1'b0);
    start = 1'b1;
    cyc(20);
    check("en_no_recount", en, 1'b0);
    start = 1'b0;
  endtask
  task automatic t_mute_short();
    mode = 4'h1;
    recount();
    mreq = 1'b1;
    hit(20);
    check("need_muted", need, 1'b0);
    mreq = 1'b0;
    cyc(10);
    brk = 1'b1;
    waitv(2, 1'b1, 20);
    brk = 1'b0;
    cyc(30);
    check("need_short", need, 1'b0);
    nomin = 1'b1;
    hit(3);
    check("need_nomin", need, 1'b1);
    nomin = 1'b0;
  endtask
  initial begin
    cyc(8);
    check("init_rst", init, 1'b1);
    check("en_rst", en, 1'b0);
    rst_n = 1'b1;
    cyc(4);
    check("init_run", init, 1'b0);
    t_modes();
    t_multi();
    t_break();
    t_mute_short();
    arm(1);
    waitv(0, 1'b0, WK + 100);
    rfree = 1'b1;
    cyc(12);
    check("restart_free", rinh, 1'b1);
    rfree = 1'b0;
    cyc(12);
    check("restart_inh", rinh, 1'b0);
    close_out();
  end
endmodule
